// ### design/scs_pkg.sv
/*
  Package for the system clock select and internal oscillator trim block:
  register addresses, field positions, reset values and cycle counts.
  Assumes one core clock domain; oscillator edges arrive as tick pulses.
*/
package scs_pkg;
  localparam logic [7:0] SCS_ADDR_SEL = 8'ha9;
  localparam logic [7:0] SCS_ADDR_CTRL = 8'hb2;
  localparam logic [7:0] SCS_ADDR_TRIM = 8'hb3;

  localparam int SCS_RDY_BIT = 7;
  localparam int SCS_DIV_LSB = 4;
  localparam int SCS_ZERO_BIT = 3;
  localparam int SCS_SRC_LSB = 0;
  localparam int SCS_SSE_BIT = 3;
  localparam int SCS_POST_LSB = 0;

  localparam logic [2:0] SCS_SRC_INT = 3'h0;
  localparam logic [2:0] SCS_SRC_EXT = 3'h1;
  localparam logic [2:0] SCS_DIV_RST = 3'h0;
  localparam logic [2:0] SCS_SRC_RST = 3'h0;
  localparam logic [1:0] SCS_POST_RST = 2'h0;
  localparam logic SCS_SSE_RST = 1'b0;

  // source cycles between divider update points
  localparam int SCS_DIV_WINDOW = 128;
  // dither: triangle period and step spacing in oscillator cycles
  localparam int SCS_TRI_PERIOD = 384;
  localparam int SCS_STEP_CYCLES = 32;
  localparam int SCS_TRI_STEPS = SCS_TRI_PERIOD / SCS_STEP_CYCLES;
  localparam int SCS_MAX_STEPS = 3;

  typedef enum logic {SCS_RUN = 1'b0, SCS_SWAP = 1'b1} scs_swap_e;
endpackage

// ### design/scs_dither.sv
/*
  Spread-spectrum dither: steps the oscillator trim along a stepped
  triangle. Assumes osc_tick pulses once per raw internal oscillator cycle.
*/
module scs_dither
  import scs_pkg::*;
#(
  parameter int TRIM_PER_STEP = 1
) (
  input wire logic clock, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic enable, // dither on
  input wire logic osc_tick, // one raw oscillator cycle
  input wire logic [6:0] base_trim, // software trim
  output logic [6:0] trim_out // trim to the oscillator
);
  import scs_pkg::*;

  // three steps either side must fit the trim range without wrapping the product
  if (TRIM_PER_STEP < 1 || TRIM_PER_STEP * SCS_MAX_STEPS > 63) begin : g_bad_step
    $error("scs_dither: TRIM_PER_STEP out of range");
  end

  typedef struct packed {
    logic [4:0] cyc;
    logic [3:0] phase;
    logic [6:0] trim;
  } scs_dither_s;

  scs_dither_s s_q, s_d;

  // triangle 0,1,2,3,2,1,0,-1,-2,-3,-2,-1 in steps
  function automatic logic signed [3:0] tri_level(input logic [3:0] ph);
    logic signed [4:0] p;
    p = signed'({1'b0, ph});
    if (p <= 5'sd3) begin
      tri_level = p[3:0];
    end else if (p <= 5'sd9) begin
      tri_level = 4'(5'sd6 - p);
    end else begin
      tri_level = 4'(p - 5'sd12);
    end
  endfunction

  logic signed [8:0] sum;

  always_comb begin
    s_d = s_q;
    sum = signed'({2'b00, base_trim})
        + 9'(tri_level(s_q.phase)) * signed'(9'(TRIM_PER_STEP));
    if (!enable) begin
      s_d.cyc = 5'h00;
      s_d.phase = 4'h0;
      s_d.trim = base_trim;
    end else begin
      if (osc_tick) begin
        s_d.cyc = s_q.cyc + 5'h01;
        if (s_q.cyc == 5'(SCS_STEP_CYCLES - 1)) begin
          // 12 steps of 32 make 384
          s_d.phase = (s_q.phase == 4'(SCS_TRI_STEPS - 1)) ? 4'h0 : s_q.phase + 4'h1;
        end
      end
      if (sum < 9'sd0) begin
        s_d.trim = 7'h00;
      end else if (sum > 9'sd127) begin
        s_d.trim = 7'h7f;
      end else begin
        s_d.trim = sum[6:0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign trim_out = s_q.trim;

  a_dither_off_base: assert property (@(posedge clock) disable iff (reset)
    !enable ##1 !enable |-> trim_out == $past(base_trim))
    else $error("trim differs from base while dither off");
  a_dither_phase_wrap: assert property (@(posedge clock) disable iff (reset)
    s_q.phase <= 4'(SCS_TRI_STEPS - 1))
    else $error("triangle phase out of range");
endmodule

// ### design/scs_divider.sv
/*
  Power-of-two divider for the selected source. New divide codes are taken
  only at the 128-cycle window boundary, so phases are never cut short.
*/
module scs_divider
  import scs_pkg::*;
(
  input wire logic clock, // core clock
  input wire logic reset, // synchronous, active high
  input wire logic src_tick, // one undivided source cycle
  input wire logic [2:0] div_code, // requested divide code
  output logic core_tick, // one divided cycle, registered
  output logic ready // requested code is in use
);
  import scs_pkg::*;

  typedef struct packed {
    logic [6:0] cnt;
    logic [2:0] applied;
    logic tick;
  } scs_div_s;

  scs_div_s s_q, s_d;
  logic [6:0] mask;

  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    mask = 7'((8'h01 << s_q.applied) - 8'h01);
    if (src_tick) begin
      s_d.cnt = s_q.cnt + 7'h01;
      // one output cycle per 2^code source cycles
      s_d.tick = ((s_q.cnt & mask) == mask);
      // switch only where all ratios align
      if (s_q.cnt == 7'(SCS_DIV_WINDOW - 1)) begin
        s_d.applied = div_code;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign core_tick = s_q.tick;
  // ready once the window boundary applied the code
  assign ready = (s_q.applied == div_code);

  a_div_apply_window: assert property (@(posedge clock) disable iff (reset)
    s_q.applied != $past(s_q.applied) |-> $past(s_q.cnt) == 7'h7f)
    else $error("divide code applied off the window boundary");
  a_div_by_one: assert property (@(posedge clock) disable iff (reset)
    src_tick && s_q.applied == 3'h0 |=> core_tick)
    else $error("divide by one missed a source cycle");
endmodule

// ### design/scs_clock_ctrl.sv
/*
  System clock select and internal oscillator trim. Holds the clock select,
  oscillator control and trim registers on the register port, picks and
  divides the clock source and drives the dither logic.
  Assumes oscillator edges arrive as one-cycle ticks synchronous to clock,
  each oscillator slower than clock, and register accesses single-cycle.
*/
// Summary of operation
// - bit 7 of clock select reads 1 once divide setting applies
// - bits 6:4 divide the source by two to the field value
// - bit 3 of clock select reads zero; software writes zero
// - bits 2:0 pick source: 000 internal, 001 external, rest reserved
// - clock select resets to zero, internal oscillator by default
// - trim bits 6:0 set period, zeros fastest, ones slowest
// - trim loads factory value on reset
// - internal post-scaler divides by 1, 2, 4, 8; resets to 8
// - dither is a stepped triangle at oscillator frequency over 384
// - dither steps about 0.25 percent, within 0.75 percent
// - a new dither step every 32 oscillator cycles
// - divider change may take 128 source cycles; poll ready flag
// - source switch while running, after one slower-oscillator period
// - post-scaler codes 00, 01, 10 give divide by 8, 4, 2
// - spread-spectrum enable bit turns dithering on and off
module scs_clock_ctrl
  import scs_pkg::*;
#(
  parameter int TRIM_PER_STEP = 1
) (
  input wire logic clock, // core clock, 25 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] sfr_addr, // register address
  input wire logic sfr_wr, // write strobe
  input wire logic sfr_rd, // read strobe
  input wire logic [7:0] sfr_wdata, // write data
  output logic [7:0] sfr_rdata, // read data, valid the cycle after sfr_rd
  input wire logic [6:0] factory_trim, // per-part trim value
  input wire logic int_osc_tick, // raw internal oscillator cycle
  input wire logic ext_osc_tick, // external oscillator cycle
  output logic [6:0] osc_period_trim, // trim to internal oscillator
  output logic core_clock, // divided system clock cycle pulse
  output logic divide_applied_flag // divide setting in use
);
  import scs_pkg::*;

  typedef struct packed {
    logic [2:0] clock_source_field;
    logic [2:0] core_clock_divider_field;
    logic [6:0] trim;
    logic [1:0] hf_osc_postscale;
    logic spread_spectrum_on;
    logic [7:0] rdata;
    scs_swap_e swap;
    logic ext_active;
    logic target_ext;
    logic seen_int;
    logic seen_ext;
    logic [2:0] post_cnt;
    logic int_tick;
    logic rdy;
  } scs_ctrl_s;

  scs_ctrl_s s_q, s_d;

  logic src_tick;
  logic div_tick;
  logic div_ready;
  logic [6:0] dith_trim;
  logic [2:0] post_mask;
  logic [7:0] sel_view;
  logic want_ext;
  logic src_legal;

  // the dither offset must stay inside the 7-bit trim range
  if (TRIM_PER_STEP < 1 || TRIM_PER_STEP * SCS_MAX_STEPS > 63) begin : g_bad_step
    $error("scs_clock_ctrl: TRIM_PER_STEP out of range");
  end

  // source to the divider; held still during a swap
  assign src_tick = (s_q.swap == SCS_RUN) &&
                    (s_q.ext_active ? ext_osc_tick : s_q.int_tick);

  scs_divider u_divider (
    .clock(clock),
    .reset(reset),
    .src_tick(src_tick),
    .div_code(s_q.core_clock_divider_field),
    .core_tick(div_tick),
    .ready(div_ready)
  );

  scs_dither #(
    .TRIM_PER_STEP(TRIM_PER_STEP)
  ) u_dither (
    .clock(clock),
    .reset(reset),
    .enable(s_q.spread_spectrum_on),
    .osc_tick(int_osc_tick),
    .base_trim(s_q.trim),
    .trim_out(dith_trim)
  );

  // ready flag on top, bit 3 fixed at zero
  assign sel_view = {s_q.rdy, s_q.core_clock_divider_field, 1'b0, s_q.clock_source_field};

  always_comb begin
    s_d = s_q;
    post_mask = 3'h0;
    want_ext = (s_q.clock_source_field == SCS_SRC_EXT);
    src_legal = (s_q.clock_source_field == SCS_SRC_INT) || want_ext;

    // register writes; reserved bits are dropped
    if (sfr_wr) begin
      if (sfr_addr == SCS_ADDR_SEL) begin
        s_d.core_clock_divider_field = sfr_wdata[SCS_DIV_LSB +: 3];
        s_d.clock_source_field = sfr_wdata[SCS_SRC_LSB +: 3];
      end else if (sfr_addr == SCS_ADDR_CTRL) begin
        s_d.spread_spectrum_on = sfr_wdata[SCS_SSE_BIT];
        s_d.hf_osc_postscale = sfr_wdata[SCS_POST_LSB +: 2];
      end else if (sfr_addr == SCS_ADDR_TRIM) begin
        s_d.trim = sfr_wdata[6:0];
      end
    end

    // flag drops on any new divide write, set by the divider
    s_d.rdy = div_ready && !(sfr_wr && sfr_addr == SCS_ADDR_SEL &&
              sfr_wdata[SCS_DIV_LSB +: 3] != s_q.core_clock_divider_field);

    if (sfr_rd) begin
      if (sfr_addr == SCS_ADDR_SEL) begin
        s_d.rdata = sel_view;
      end else if (sfr_addr == SCS_ADDR_CTRL) begin
        s_d.rdata = {4'h0, s_q.spread_spectrum_on, 1'b0, s_q.hf_osc_postscale};
      end else if (sfr_addr == SCS_ADDR_TRIM) begin
        s_d.rdata = {1'b0, s_q.trim};
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // post-scaler: 00 by 8, 01 by 4, 10 by 2, 11 by 1
    case (s_q.hf_osc_postscale)
      2'h0: post_mask = 3'h7;
      2'h1: post_mask = 3'h3;
      2'h2: post_mask = 3'h1;
      default: post_mask = 3'h0;
    endcase
    s_d.int_tick = 1'b0;
    if (int_osc_tick) begin
      s_d.post_cnt = s_q.post_cnt + 3'h1;
      s_d.int_tick = ((s_q.post_cnt & post_mask) == post_mask);
    end

    // swap waits for a full cycle of both oscillators
    case (s_q.swap)
      SCS_RUN: begin
        // reserved codes keep the running source
        if (src_legal && want_ext != s_q.ext_active) begin
          s_d.swap = SCS_SWAP;
          s_d.target_ext = want_ext;
          s_d.seen_int = 1'b0;
          s_d.seen_ext = 1'b0;
        end
      end
      default: begin
        if (s_q.int_tick) begin
          s_d.seen_int = 1'b1;
        end
        if (ext_osc_tick) begin
          s_d.seen_ext = 1'b1;
        end
        if (s_q.seen_int && s_q.seen_ext) begin
          // both clocks have completed a cycle since the swap began: clean handover
          s_d.ext_active = s_q.target_ext;
          s_d.swap = SCS_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      // clock select all zero: internal oscillator
      s_q.clock_source_field <= SCS_SRC_RST;
      s_q.core_clock_divider_field <= SCS_DIV_RST;
      // per-part trim caught while reset is held
      s_q.trim <= factory_trim;
      // post-scaler back to divide by 8
      s_q.hf_osc_postscale <= SCS_POST_RST;
      s_q.spread_spectrum_on <= SCS_SSE_RST;
      s_q.rdata <= 8'h00;
      s_q.swap <= SCS_RUN;
      s_q.ext_active <= 1'b0;
      s_q.target_ext <= 1'b0;
      s_q.seen_int <= 1'b0;
      s_q.seen_ext <= 1'b0;
      s_q.post_cnt <= 3'h0;
      s_q.int_tick <= 1'b0;
      s_q.rdy <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sfr_rdata = s_q.rdata;
  assign osc_period_trim = dith_trim;
  assign core_clock = div_tick;
  assign divide_applied_flag = s_q.rdy;

  sequence swap_start;
    s_q.swap == SCS_RUN ##1 s_q.swap == SCS_SWAP;
  endsequence

  sequence swap_hold;
    !src_tick [*2];
  endsequence

  a_sel_bit_zero: assert property (@(posedge clock) disable iff (reset)
    $past(sfr_rd) && $past(sfr_addr) == SCS_ADDR_SEL |-> !sfr_rdata[SCS_ZERO_BIT])
    else $error("clock select bit 3 read as one");
  a_rdy_after_write: assert property (@(posedge clock) disable iff (reset)
    sfr_wr && sfr_addr == SCS_ADDR_SEL &&
    sfr_wdata[SCS_DIV_LSB +: 3] != s_q.core_clock_divider_field |=> !divide_applied_flag)
    else $error("ready flag stayed set after divide change");
  a_rdy_within_window: assert property (@(posedge clock) disable iff (reset)
    !div_ready && s_q.core_clock_divider_field == $past(s_q.core_clock_divider_field)
    ##1 div_ready |=> divide_applied_flag)
    else $error("ready flag missed the applied divide");
  a_swap_holds_clock: assert property (@(posedge clock) disable iff (reset)
    swap_start |-> swap_hold)
    else $error("source ticks passed during a swap");
  a_swap_needs_both: assert property (@(posedge clock) disable iff (reset)
    $changed(s_q.ext_active) |-> $past(s_q.seen_int) && $past(s_q.seen_ext))
    else $error("source switched before both oscillators cycled");
  a_reset_defaults: assert property (@(posedge clock)
    $past(reset) |-> s_q.clock_source_field == 3'h0 && s_q.core_clock_divider_field == 3'h0
    && s_q.hf_osc_postscale == 2'h0 && !s_q.ext_active)
    else $error("clock select not zero after reset");
  a_post_by_eight: assert property (@(posedge clock) disable iff (reset)
    s_q.hf_osc_postscale == 2'h0 && int_osc_tick && s_q.post_cnt != 3'h7
    |=> !s_q.int_tick)
    else $error("post-scaler ticked early at divide by eight");
  a_trim_write: assert property (@(posedge clock) disable iff (reset)
    sfr_wr && sfr_addr == SCS_ADDR_TRIM |=> s_q.trim == $past(sfr_wdata[6:0]))
    else $error("trim write not stored");

  // register read views
  a_trim_read_view: assert property (@(posedge clock) disable iff (reset)
    sfr_rd && sfr_addr == SCS_ADDR_TRIM |=> sfr_rdata == {1'b0, $past(s_q.trim)})
    else $error("trim read differs from stored trim");
  a_sel_read_flag: assert property (@(posedge clock) disable iff (reset)
    sfr_rd && sfr_addr == SCS_ADDR_SEL |=> sfr_rdata[SCS_RDY_BIT] == $past(s_q.rdy))
    else $error("select read shows wrong ready flag");
  a_ctrl_read_zero: assert property (@(posedge clock) disable iff (reset)
    sfr_rd && sfr_addr == SCS_ADDR_CTRL |=> sfr_rdata[7:4] == 4'h0 && !sfr_rdata[2])
    else $error("control read shows unused bits set");
  a_rdata_holds: assert property (@(posedge clock) disable iff (reset)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");

  // source routing and swap
  a_ext_source_ticks: assert property (@(posedge clock) disable iff (reset)
    s_q.swap == SCS_RUN && s_q.ext_active |-> src_tick == ext_osc_tick)
    else $error("external source ticks not routed");
  a_int_source_ticks: assert property (@(posedge clock) disable iff (reset)
    s_q.swap == SCS_RUN && !s_q.ext_active |-> src_tick == s_q.int_tick)
    else $error("internal source ticks not routed");
  a_reserved_keeps: assert property (@(posedge clock) disable iff (reset)
    s_q.swap == SCS_RUN && !src_legal |=> s_q.swap == SCS_RUN)
    else $error("reserved source code started a swap");
  a_no_tick_idle: assert property (@(posedge clock) disable iff (reset)
    !src_tick |=> !core_clock)
    else $error("core clock pulse without a source cycle");

  // post-scaler codes
  a_post_by_one: assert property (@(posedge clock) disable iff (reset)
    s_q.hf_osc_postscale == 2'h3 && int_osc_tick |=> s_q.int_tick)
    else $error("post-scaler by one missed an oscillator cycle");
  a_post_by_four: assert property (@(posedge clock) disable iff (reset)
    s_q.hf_osc_postscale == 2'h1 && int_osc_tick && s_q.post_cnt[1:0] != 2'h3
    |=> !s_q.int_tick)
    else $error("post-scaler ticked early at divide by four");
  a_post_by_two: assert property (@(posedge clock) disable iff (reset)
    s_q.hf_osc_postscale == 2'h2 && int_osc_tick && !s_q.post_cnt[0]
    |=> !s_q.int_tick)
    else $error("post-scaler ticked early at divide by two");

  // control, flag and reset loading
  a_sse_write: assert property (@(posedge clock) disable iff (reset)
    sfr_wr && sfr_addr == SCS_ADDR_CTRL
    |=> s_q.spread_spectrum_on == $past(sfr_wdata[SCS_SSE_BIT]))
    else $error("spread-spectrum enable write not stored");
  a_flag_from_divider: assert property (@(posedge clock) disable iff (reset)
    divide_applied_flag |-> $past(div_ready))
    else $error("ready flag set while divider not ready");
  a_trim_reset_load: assert property (@(posedge clock)
    $past(reset) |-> s_q.trim == $past(factory_trim))
    else $error("trim did not load the factory value in reset");
endmodule

// ### dv/testbench.sv
/*
  Self-checking bench for the system clock select and oscillator trim block.
  Assumes the block's registers are reached only through its own register port,
  and that the oscillator ticks come from this bench, each slower than clock.
*/
module testbench;
  import scs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic [6:0] factory_trim = 7'h2a;
  logic int_osc_tick = 1'b0;
  logic ext_osc_tick = 1'b0;
  logic [6:0] osc_period_trim;
  logic core_clock;
  logic divide_applied_flag;
  int error_cnt = 0;
  int n_tests = 0;
  int iper = 2;
  int eper = 3;
  int icnt = 0;
  int ecnt = 0;

  scs_clock_ctrl #(.TRIM_PER_STEP(1)) i_scs_clock_ctrl (
    .clock(clock), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .factory_trim(factory_trim), .int_osc_tick(int_osc_tick),
    .ext_osc_tick(ext_osc_tick), .osc_period_trim(osc_period_trim),
    .core_clock(core_clock), .divide_applied_flag(divide_applied_flag)
  );

  always #20 clock = ~clock;

  // oscillator ticks: fixed spacing keeps expected periods simple multiples
  always @(posedge clock) begin
    #1;
    icnt = (icnt + 1 >= iper) ? 0 : icnt + 1;
    ecnt = (ecnt + 1 >= eper) ? 0 : ecnt + 1;
    int_osc_tick = (icnt == 0);
    ext_osc_tick = (ecnt == 0);
  end

  task automatic conclude();
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // an idle cycle after each access keeps strobes from being re-driven at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    cmp(16'(d), 16'(e), "register read");
    cyc(1);
  endtask

  // second full interval between core clock pulses, so a switch-over is left behind
  task automatic period(output int n);
    int k;
    k = 0;
    for (int p = 0; p < 3; p++) begin
      k = 0;
      do begin
        cyc(1);
        k++;
      end while (core_clock !== 1'b1 && k < 5000);
    end
    n = k;
  endtask

  task automatic next_change(output int t, output logic [6:0] v);
    logic [6:0] old;
    old = osc_period_trim;
    t = 0;
    do begin
      @(negedge clock);
      if (int_osc_tick === 1'b1) t++;
    end while (osc_period_trim === old && t < 100);
    v = osc_period_trim;
    cyc(1);
  endtask

  task automatic t_reset();
    cyc(3);
    chk(SCS_ADDR_SEL, 8'h80);
    chk(SCS_ADDR_CTRL, 8'h00);
    chk(SCS_ADDR_TRIM, 8'h2a);
    cmp(16'(osc_period_trim), 16'h002a, "trim port after reset");
    wr(8'h10, 8'hff);
    chk(8'h10, 8'h00);
    $display("test reset values done");
  endtask

  task automatic t_divider();
    int n;
    logic [2:0] d;
    wr(SCS_ADDR_CTRL, 8'h03);
    for (int i = 1; i <= 8; i++) begin
      d = 3'(i % 8);
      wr(SCS_ADDR_SEL, {1'b0, d, 4'h0});
      cmp(16'(divide_applied_flag), 16'h0000, "flag while pending");
      n = 0;
      while (divide_applied_flag !== 1'b1 && n < 300) begin
        cyc(1);
        n++;
      end
      cmp(16'(divide_applied_flag), 16'h0001, "flag within window");
      chk(SCS_ADDR_SEL, {1'b1, d, 4'h0});
      period(n);
      cmp(16'(n), 16'(2 << d), "divided period");
    end
    $display("test divider done");
  endtask

  task automatic t_postscale();
    int n;
    for (int c = 0; c < 4; c++) begin
      wr(SCS_ADDR_CTRL, 8'(c));
      chk(SCS_ADDR_CTRL, 8'(c));
      period(n);
      cmp(16'(n), 16'(2 << (3 - c)), "post-scaled period");
    end
    $display("test post-scaler done");
  endtask

  task automatic t_source();
    int n;
    wr(SCS_ADDR_SEL, 8'h01);
    period(n);
    cmp(16'(n), 16'd3, "external period");
    chk(SCS_ADDR_SEL, 8'h81);
    wr(SCS_ADDR_SEL, 8'h07);
    period(n);
    cmp(16'(n), 16'd3, "reserved code keeps source");
    wr(SCS_ADDR_SEL, 8'h08);
    chk(SCS_ADDR_SEL, 8'h80);
    period(n);
    cmp(16'(n), 16'd2, "back on internal");
    $display("test source select done");
  endtask

  task automatic t_trim();
    wr(SCS_ADDR_TRIM, 8'hff);
    chk(SCS_ADDR_TRIM, 8'h7f);
    cmp(16'(osc_period_trim), 16'h007f, "slowest trim");
    wr(SCS_ADDR_TRIM, 8'h00);
    chk(SCS_ADDR_TRIM, 8'h00);
    cmp(16'(osc_period_trim), 16'h0000, "fastest trim");
    $display("test trim done");
  endtask

  task automatic t_dither();
    int t;
    logic [6:0] v;
    logic [6:0] mn;
    logic [6:0] mx;
    mn = 7'h7f;
    mx = 7'h00;
    wr(SCS_ADDR_TRIM, 8'h40);
    wr(SCS_ADDR_CTRL, 8'h0b);
    next_change(t, v);
    for (int s = 0; s < 12; s++) begin
      next_change(t, v);
      cmp(16'(t), 16'd32, "ticks per step");
      mn = (v < mn) ? v : mn;
      mx = (v > mx) ? v : mx;
    end
    cmp(16'(mn), 16'h003d, "lowest dither trim");
    cmp(16'(mx), 16'h0043, "highest dither trim");
    wr(SCS_ADDR_CTRL, 8'h03);
    cyc(2);
    cmp(16'(osc_period_trim), 16'h0040, "dither off");
    $display("test dither done");
  endtask

  task automatic t_rereset();
    int n;
    wr(SCS_ADDR_SEL, 8'h31);
    wr(SCS_ADDR_CTRL, 8'h0b);
    factory_trim = 7'h55;
    reset = 1'b1;
    cyc(4);
    reset = 1'b0;
    cyc(3);
    chk(SCS_ADDR_SEL, 8'h80);
    chk(SCS_ADDR_CTRL, 8'h00);
    chk(SCS_ADDR_TRIM, 8'h55);
    period(n);
    cmp(16'(n), 16'd16, "divide by 8 after reset");
    $display("test second reset done");
  endtask

  initial begin
    repeat (8) @(posedge clock);
    #1;
    reset = 1'b0;
    t_reset();
    t_divider();
    t_postscale();
    t_source();
    t_trim();
    t_dither();
    t_rereset();
    conclude();
  end

  // the whole sequence needs about 4000 cycles
  initial begin
    #(40 * 60000);
    error_cnt++;
    conclude();
  end
endmodule
